// *** verilog/uic_pkg.sv ***
// constants, field layouts and carrier types of the usb interface configuration block
// Overview of operation
// - any write to reset register clears interface state
// - control bit 0 enables token processing
// - control bit 1 enables token checking
// - control bit 2 enables line-state decoder
// - control bit 4 enables interface timing mode
// - control bit 5 enables power signalling mode
// - control bit 6 treats frame start as token
// - control bit 7 enables event acknowledge mode
// - seven-bit address; forward only matching packets
// - function bits 4:2 drive opmode, reset one
// - function bit 1 drives termselect, reset one
// - function bit 0 drives xcvrselect, reset one
// - otg bit 7 selects external vbus indicator
// - otg bit 6 enables external vbus drive
// - otg bit 4 drives vbus charge control
// - otg bit 3 drives vbus discharge control
// - otg bit 2 drives d-minus pull-down
// - otg bit 1 drives d-plus pull-down
// - otg bit 0 enables id pin pull-up
// - bank answers peripheral 1, 32-bit accesses only
package uic_pkg;
    // peripheral number of this register bank
    localparam logic [7:0]  PERIPH_ID      = 8'h01;
    // register offsets
    localparam logic [7:0]  OFS_SOFT_RST   = 8'h00;
    localparam logic [7:0]  OFS_MODE       = 8'h04;
    localparam logic [7:0]  OFS_DEV_ADDR   = 8'h08;
    localparam logic [7:0]  OFS_FUNC       = 8'h0C;
    localparam logic [7:0]  OFS_OTG_CTL    = 8'h10;
    localparam logic [7:0]  OFS_OTG_FLAGS  = 8'h14;
    localparam logic [7:0]  OFS_SERIAL     = 8'h18;
    localparam logic [7:0]  OFS_LINE_FLAGS = 8'h1C;
    localparam logic [7:0]  OFS_HOLD_SEL   = 8'h20;
    localparam logic [7:0]  OFS_PORT_MASK  = 8'h24;
    localparam logic [7:0]  OFS_FRAME_NUM  = 8'h28;
    localparam logic [7:0]  OFS_LAST_PID   = 8'h2C;
    localparam logic [7:0]  OFS_LAST_EP    = 8'h30;
    localparam logic [7:0]  OFS_EP_MARK    = 8'h34;
    localparam logic [7:0]  OFS_OTG_MASK   = 8'h38;
    localparam logic [7:0]  OFS_PWR_SIG    = 8'h3C;
    localparam logic [7:0]  OFS_XCVR_CTL   = 8'h40;
    // writable bit masks of the control registers
    localparam logic [7:0]  MODE_WR_MASK   = 8'hF7;
    localparam logic [7:0]  OTG_WR_MASK    = 8'hDF;
    // values after reset
    localparam logic [7:0]  MODE_RST       = 8'h00;
    localparam logic [6:0]  DEV_ADDR_RST   = 7'h00;
    localparam logic [4:0]  FUNC_RST       = 5'h07;
    localparam logic [7:0]  OTG_RST        = 8'h00;
    localparam logic [3:0]  SERIAL_RST     = 4'h2;
    // field positions
    localparam int          FLAG_TOKEN_BIT = 6;
    localparam int          FLAG_CNT       = 7;

    // request from the processor side
    typedef struct packed {
        logic [7:0]  periph;  // peripheral number
        logic        wr;      // 32-bit write strobe
        logic        rd;      // 32-bit read strobe
        logic [7:0]  addr;    // register offset
        logic [31:0] wdata;   // write data
    } uic_req_t;

    // interface machine mode enables, bit order of the control register without the reserved bit
    typedef struct packed {
        logic event_acknowledge_mode;
        logic frame_start_as_token_mode;
        logic power_signal_mode;
        logic if_timing_mode;
        logic line_decoder_en;
        logic token_checking_mode;
        logic token_processing_mode;
    } uic_mode_t;

    // transceiver selects, same layout as the function control register
    typedef struct packed {
        logic [2:0] opmode;
        logic       termselect;
        logic       xcvrselect;
    } uic_func_t;

    // on-the-go controls, layout of the otg control register without the reserved bit
    typedef struct packed {
        logic external_vbus_indicator_mode;
        logic external_vbus_drive_mode;
        logic chrgvbus;
        logic dischrgvbus;
        logic dmpulldown;
        logic dppulldown;
        logic id_pin_pullup;
    } uic_otg_t;
endpackage : uic_pkg

// *** verilog/uic_flag_bank.sv ***
// line event flags, each either following its source or held until cleared
`timescale 1ns/1ns
module uic_flag_bank #(
    parameter int N = 7                 // number of flags
) (
    input  wire logic         core_clk, // system clock
    input  wire logic         reset,    // synchronous reset, active high
    input  wire logic         soft_clr, // interface soft reset
    input  wire logic [N-1:0] src,      // flag sources
    input  wire logic [N-1:0] hold_sel, // one holds the flag
    input  wire logic [N-1:0] clr,      // one-cycle clear per flag
    output logic      [N-1:0] flags_ff  // flag values
);
    // elaboration check on the width
    if (N < 1 || N > 32) begin : g_bad_n
        $error("uic_flag_bank: N must be 1 to 32");
    end

    // one process per flag; a source that arrives with the clear wins
    for (genvar i = 0; i < N; i++) begin : g_flag
        always_ff @(posedge core_clk) begin
            if (reset || soft_clr) begin
                flags_ff[i] <= 1'b0;
            end else if (hold_sel[i]) begin
                flags_ff[i] <= src[i] | (flags_ff[i] & ~clr[i]);
            end else begin
                flags_ff[i] <= src[i];
            end
        end
    end
endmodule : uic_flag_bank

// *** verilog/uic_port_mask.sv ***
// one flag-driven port line: high while any selected flag is high
`timescale 1ns/1ns
module uic_port_mask #(
    parameter int N = 7                   // number of flags
) (
    input  wire logic         core_clk,   // system clock
    input  wire logic         reset,      // synchronous reset, active high
    input  wire logic [N-1:0] flags,      // flag values
    input  wire logic [7:0]   mask,       // flag select for this port
    output logic              port_ff     // registered port level
);
    // the mask byte must cover every flag
    if (N < 1 || N > 8) begin : g_bad_n
        $error("uic_port_mask: N must be 1 to 8");
    end

    // or of the selected flags, registered
    always_ff @(posedge core_clk) begin
        if (reset) begin
            port_ff <= 1'b0;
        end else begin
            port_ff <= |(flags & mask[N-1:0]);
        end
    end
endmodule : uic_port_mask

// *** verilog/uic_cfg.sv ***
// register bank of the usb interface machine: modes, address filter, transceiver and otg controls
`timescale 1ns/1ns
module uic_cfg #(
    parameter int N_PORTS = 4                        // flag-driven port lines
) (
    input  wire logic             core_clk,          // system clock, 250 MHz
    input  wire logic             reset,             // synchronous reset, active high
    input  wire uic_pkg::uic_req_t req,              // processor-side request
    output logic                  ack_ff,            // access taken, one cycle
    output logic [31:0]           rdata_ff,          // read data, valid with ack_ff
    input  wire logic [6:0]       flag_src,          // line and error events
    input  wire logic             tok_valid,         // decoded token strobe
    input  wire logic [6:0]       tok_addr,          // token device address
    input  wire logic [3:0]       tok_pid,           // token packet id
    input  wire logic [3:0]       tok_ep,            // token endpoint
    input  wire logic [5:0]       otg_flags,         // transceiver otg status
    input  wire logic [2:0]       rx_line,           // serial receive status
    output logic                  tok_fwd_ff,        // token passed the filter, one cycle
    output logic                  ifm_clr_ff,        // interface state clear, one cycle
    output uic_pkg::uic_mode_t    mode_ff,           // mode enables
    output logic [6:0]            dev_addr_ff,       // stored device address
    output uic_pkg::uic_func_t    func_ff,           // transceiver selects
    output uic_pkg::uic_otg_t     otg_ff,            // on-the-go controls
    output logic [3:0]            serial_ctl_ff,     // serial transmit controls
    output logic [N_PORTS-1:0]    port_ff            // flag-driven port lines
);
    // the port mask register holds four bytes
    if (N_PORTS < 1 || N_PORTS > 4) begin : g_bad_ports
        $error("uic_cfg: N_PORTS must be 1 to 4");
    end

    // decoded access
    logic                 hit;            // request aimed at this peripheral
    logic                 wr_hit;         // write to this peripheral
    logic                 rd_hit;         // read from this peripheral
    logic                 soft_clr;       // write to the reset register
    logic [31:0]          nxt_rdata;      // read mux output
    // register storage
    logic [6:0]           hold_sel_ff;    // flag hold select
    logic [31:0]          port_mask_ff;   // port mask bytes
    logic [10:0]          frame_num_ff;   // frame counter
    logic [3:0]           last_pid_ff;    // last packet id
    logic [4:0]           last_ep_ff;     // valid bit and last endpoint
    logic [15:0]          ep_mark_ff;     // endpoint marks
    logic [31:0]          otg_mask_ff;    // otg flag mask
    logic [8:0]           pwr_sig_ff;     // power signalling value
    logic [31:0]          xcvr_ctl_ff;    // transceiver control word
    logic [6:0]           line_flags;     // flag bank output
    logic [6:0]           flag_clr;       // flag clears from software
    logic [6:0]           flag_in;        // flag sources incl. token match
    logic                 tok_match;      // token address equals stored address

    // only full-word accesses to peripheral 1 are taken
    always_comb begin
        hit    = (req.periph == uic_pkg::PERIPH_ID);
        wr_hit = hit && req.wr;
        rd_hit = hit && req.rd && !req.wr;
        soft_clr = wr_hit && (req.addr == uic_pkg::OFS_SOFT_RST);
    end

    // one-cycle acknowledge for every taken access
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= wr_hit || rd_hit;
        end
    end

    // interface clear pulse to the machine; transceiver selects and otg controls stay as they are
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ifm_clr_ff <= 1'b0;
        end else begin
            ifm_clr_ff <= soft_clr;
        end
    end

    // mode enables; cleared with the interface state
    always_ff @(posedge core_clk) begin
        if (reset || soft_clr) begin
            mode_ff <= uic_pkg::uic_mode_t'({uic_pkg::MODE_RST[7:4], uic_pkg::MODE_RST[2:0]});
        end else if (wr_hit && req.addr == uic_pkg::OFS_MODE) begin
            // bit 3 is reserved and dropped
            mode_ff <= uic_pkg::uic_mode_t'({req.wdata[7:4], req.wdata[2:0]});
        end
    end

    // device address used by the packet filter
    always_ff @(posedge core_clk) begin
        if (reset || soft_clr) begin
            dev_addr_ff <= uic_pkg::DEV_ADDR_RST;
        end else if (wr_hit && req.addr == uic_pkg::OFS_DEV_ADDR) begin
            dev_addr_ff <= req.wdata[6:0];
        end
    end

    // token filter: only tokens to the stored address go on
    always_comb begin
        tok_match = tok_valid && (tok_addr == dev_addr_ff);
    end

    // forwarded token strobe
    always_ff @(posedge core_clk) begin
        if (reset || soft_clr) begin
            tok_fwd_ff <= 1'b0;
        end else begin
            tok_fwd_ff <= tok_match;
        end
    end

    // transceiver selects; not touched by the interface clear
    always_ff @(posedge core_clk) begin
        if (reset) begin
            func_ff <= uic_pkg::uic_func_t'(uic_pkg::FUNC_RST);
        end else if (wr_hit && req.addr == uic_pkg::OFS_FUNC) begin
            func_ff <= uic_pkg::uic_func_t'(req.wdata[4:0]);
        end
    end

    // on-the-go controls; not touched by the interface clear
    always_ff @(posedge core_clk) begin
        if (reset) begin
            otg_ff <= uic_pkg::uic_otg_t'({uic_pkg::OTG_RST[7:6], uic_pkg::OTG_RST[4:0]});
        end else if (wr_hit && req.addr == uic_pkg::OFS_OTG_CTL) begin
            // bit 5 is reserved and dropped
            otg_ff <= uic_pkg::uic_otg_t'({req.wdata[7:6], req.wdata[4:0]});
        end
    end

    // serial transmit controls
    always_ff @(posedge core_clk) begin
        if (reset || soft_clr) begin
            serial_ctl_ff <= uic_pkg::SERIAL_RST;
        end else if (wr_hit && req.addr == uic_pkg::OFS_SERIAL) begin
            serial_ctl_ff <= req.wdata[3:0];
        end
    end

    // flag hold select and port masks
    always_ff @(posedge core_clk) begin
        if (reset || soft_clr) begin
            hold_sel_ff  <= 7'h00;
            port_mask_ff <= 32'h0000_0000;
        end else if (wr_hit) begin
            if (req.addr == uic_pkg::OFS_HOLD_SEL) begin
                hold_sel_ff <= req.wdata[6:0];
            end
            if (req.addr == uic_pkg::OFS_PORT_MASK) begin
                port_mask_ff <= req.wdata;
            end
        end
    end

    // frame counter, endpoint marks, otg mask, power signalling, transceiver word
    always_ff @(posedge core_clk) begin
        if (reset || soft_clr) begin
            frame_num_ff <= 11'h000;
            ep_mark_ff   <= 16'h0000;
            otg_mask_ff  <= 32'h0000_0000;
            pwr_sig_ff   <= 9'h000;
            xcvr_ctl_ff  <= 32'h0000_0000;
        end else if (wr_hit) begin
            case (req.addr)
                uic_pkg::OFS_FRAME_NUM: begin
                    frame_num_ff <= req.wdata[10:0];
                end
                uic_pkg::OFS_EP_MARK: begin
                    ep_mark_ff <= req.wdata[15:0];
                end
                uic_pkg::OFS_OTG_MASK: begin
                    otg_mask_ff <= req.wdata;
                end
                uic_pkg::OFS_PWR_SIG: begin
                    pwr_sig_ff <= req.wdata[8:0];
                end
                uic_pkg::OFS_XCVR_CTL: begin
                    xcvr_ctl_ff <= req.wdata;
                end
                default: begin
                    // other offsets are handled elsewhere or ignored
                end
            endcase
        end
    end

    // capture of the last forwarded token's packet id and endpoint
    always_ff @(posedge core_clk) begin
        if (reset || soft_clr) begin
            last_pid_ff <= 4'h0;
            last_ep_ff  <= 5'h00;
        end else if (tok_match) begin
            last_pid_ff <= tok_pid;
            last_ep_ff  <= {1'b1, tok_ep};
        end
    end

    // flag sources and clears: the token flag comes from the filter
    always_comb begin
        flag_in = flag_src;
        flag_in[uic_pkg::FLAG_TOKEN_BIT] = tok_match;
        flag_clr = (wr_hit && req.addr == uic_pkg::OFS_LINE_FLAGS) ? req.wdata[6:0] : 7'h00;
    end

    // line event flags
    uic_flag_bank #(
        .N        (uic_pkg::FLAG_CNT)
    ) u_flags (
        .core_clk (core_clk),
        .reset    (reset),
        .soft_clr (soft_clr),
        .src      (flag_in),
        .hold_sel (hold_sel_ff),
        .clr      (flag_clr),
        .flags_ff (line_flags)
    );

    // one port line per mask byte
    for (genvar p = 0; p < N_PORTS; p++) begin : g_port
        uic_port_mask #(
            .N        (uic_pkg::FLAG_CNT)
        ) u_port (
            .core_clk (core_clk),
            .reset    (reset),
            .flags    (line_flags),
            .mask     (port_mask_ff[8*p +: 8]),
            .port_ff  (port_ff[p])
        );
    end

    // read mux; reserved bits and unmapped offsets read zero
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        case (req.addr)
            uic_pkg::OFS_MODE: begin
                nxt_rdata[7:0] = {mode_ff[6:3], 1'b0, mode_ff[2:0]};
            end
            uic_pkg::OFS_DEV_ADDR: begin
                nxt_rdata[6:0] = dev_addr_ff;
            end
            uic_pkg::OFS_FUNC: begin
                nxt_rdata[4:0] = func_ff;
            end
            uic_pkg::OFS_OTG_CTL: begin
                nxt_rdata[7:0] = {otg_ff[6:5], 1'b0, otg_ff[4:0]};
            end
            uic_pkg::OFS_OTG_FLAGS: begin
                nxt_rdata[5:0] = otg_flags;
            end
            uic_pkg::OFS_SERIAL: begin
                nxt_rdata[6:0] = {rx_line, serial_ctl_ff};
            end
            uic_pkg::OFS_LINE_FLAGS: begin
                nxt_rdata[6:0] = line_flags;
            end
            uic_pkg::OFS_HOLD_SEL: begin
                nxt_rdata[6:0] = hold_sel_ff;
            end
            uic_pkg::OFS_PORT_MASK: begin
                nxt_rdata = port_mask_ff;
            end
            uic_pkg::OFS_FRAME_NUM: begin
                nxt_rdata[10:0] = frame_num_ff;
            end
            uic_pkg::OFS_LAST_PID: begin
                nxt_rdata[3:0] = last_pid_ff;
            end
            uic_pkg::OFS_LAST_EP: begin
                nxt_rdata[4:0] = last_ep_ff;
            end
            uic_pkg::OFS_EP_MARK: begin
                nxt_rdata[15:0] = ep_mark_ff;
            end
            uic_pkg::OFS_OTG_MASK: begin
                nxt_rdata = otg_mask_ff;
            end
            uic_pkg::OFS_PWR_SIG: begin
                nxt_rdata[8:0] = pwr_sig_ff;
            end
            uic_pkg::OFS_XCVR_CTL: begin
                nxt_rdata = xcvr_ctl_ff;
            end
            default: begin
                // reset register is write-only; unmapped reads give zero
                nxt_rdata = 32'h0000_0000;
            end
        endcase
    end

    // registered read data, zero outside a read answer
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rdata_ff <= 32'h0000_0000;
        end else begin
            rdata_ff <= rd_hit ? nxt_rdata : 32'h0000_0000;
        end
    end

    // checks
    sequence s_soft_wr;
        wr_hit && req.addr == uic_pkg::OFS_SOFT_RST;
    endsequence

    property p_soft_clear;
        @(posedge core_clk) disable iff (reset)
        s_soft_wr |=> ifm_clr_ff && mode_ff == '0 && dev_addr_ff == 7'h00;
    endproperty
    a_soft_clear: assert property (p_soft_clear) else $error("soft reset left state");

    property p_soft_keeps_phy;
        @(posedge core_clk) disable iff (reset)
        s_soft_wr |=> func_ff == $past(func_ff) && otg_ff == $past(otg_ff);
    endproperty
    a_soft_keeps_phy: assert property (p_soft_keeps_phy) else $error("soft reset changed phy");

    property p_mode_write;
        @(posedge core_clk) disable iff (reset)
        wr_hit && req.addr == uic_pkg::OFS_MODE |=>
            mode_ff.token_processing_mode == $past(req.wdata[0]) && mode_ff.token_checking_mode == $past(req.wdata[1])
            && mode_ff.line_decoder_en == $past(req.wdata[2]) && mode_ff.event_acknowledge_mode == $past(req.wdata[7]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode bits not stored");

    property p_mode_upper;
        @(posedge core_clk) disable iff (reset)
        wr_hit && req.addr == uic_pkg::OFS_MODE |=> mode_ff.if_timing_mode == $past(req.wdata[4])
            && mode_ff.power_signal_mode == $past(req.wdata[5]) && mode_ff.frame_start_as_token_mode == $past(req.wdata[6]);
    endproperty
    a_mode_upper: assert property (p_mode_upper) else $error("mode upper bits wrong");

    property p_addr_filter;
        @(posedge core_clk) disable iff (reset)
        tok_valid && !soft_clr |=> tok_fwd_ff == ($past(tok_addr) == $past(dev_addr_ff));
    endproperty
    a_addr_filter: assert property (p_addr_filter) else $error("address filter wrong");

    property p_func_write;
        @(posedge core_clk) disable iff (reset)
        wr_hit && req.addr == uic_pkg::OFS_FUNC |=> func_ff.opmode == $past(req.wdata[4:2])
            && func_ff.termselect == $past(req.wdata[1]) && func_ff.xcvrselect == $past(req.wdata[0]);
    endproperty
    a_func_write: assert property (p_func_write) else $error("function selects wrong");

    property p_otg_write;
        @(posedge core_clk) disable iff (reset)
        wr_hit && req.addr == uic_pkg::OFS_OTG_CTL |=> otg_ff.external_vbus_indicator_mode == $past(req.wdata[7])
            && otg_ff.external_vbus_drive_mode == $past(req.wdata[6]) && otg_ff.chrgvbus == $past(req.wdata[4])
            && otg_ff.dischrgvbus == $past(req.wdata[3]) && otg_ff.dmpulldown == $past(req.wdata[2])
            && otg_ff.dppulldown == $past(req.wdata[1]) && otg_ff.id_pin_pullup == $past(req.wdata[0]);
    endproperty
    a_otg_write: assert property (p_otg_write) else $error("otg controls wrong");

    property p_other_periph;
        @(posedge core_clk) disable iff (reset)
        (req.wr || req.rd) && !hit |=> !ack_ff;
    endproperty
    a_other_periph: assert property (p_other_periph) else $error("foreign access taken");

    property p_reserved_zero;
        @(posedge core_clk) disable iff (reset)
        rd_hit && req.addr == uic_pkg::OFS_MODE |=> ack_ff && rdata_ff[31:8] == 24'h000000 && !rdata_ff[3];
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");
endmodule : uic_cfg

// *** verification/uic_xcvr_model.sv ***
// behavioural transceiver: otg and line status answering the otg controls
`timescale 1ns/1ns
module uic_xcvr_model (
    input  wire logic              core_clk,  // system clock
    input  wire uic_pkg::uic_otg_t otg,       // on-the-go controls
    output logic [5:0]             otg_flags, // otg status
    output logic [2:0]             rx_line    // line status
);
    // vbus valid follows the charge control a cycle later
    always_ff @(posedge core_clk) begin
        otg_flags <= {5'h00, otg.chrgvbus};
        rx_line   <= {2'h0, otg.dppulldown};
    end
endmodule : uic_xcvr_model

// *** verification/testbench.sv ***
// self-checking bench of the usb interface configuration bank
`timescale 1ns/1ns
module testbench;
    logic core_clk = 0, reset = 1, ack_ff, tok_valid = 0, tok_fwd_ff, ifm_clr_ff, clr;
    uic_pkg::uic_req_t  req = '0;  // processor request
    uic_pkg::uic_mode_t mode_ff;   // mode enables
    uic_pkg::uic_func_t func_ff;   // transceiver selects
    uic_pkg::uic_otg_t  otg_ff;    // otg controls
    logic [31:0] rdata_ff, rd;     // read data
    logic [6:0]  tok_addr = '0;    // token address
    logic [5:0]  otg_flags;        // model status
    logic [2:0]  rx_line;          // model line
    logic [6:0]  dev_addr_ff;      // stored device address
    logic [3:0]  serial_ctl_ff;    // serial transmit controls
    logic [3:0]  port_ff;          // flag-driven port lines
    int num_errors = 0, checks = 0, cyc = 0;
    uic_cfg u_uic_cfg (.core_clk(core_clk), .reset(reset), .req(req), .ack_ff(ack_ff), .rdata_ff(rdata_ff),
        .flag_src(7'h00), .tok_valid(tok_valid), .tok_addr(tok_addr), .tok_pid(4'h0), .tok_ep(4'h0),
        .otg_flags(otg_flags), .rx_line(rx_line), .tok_fwd_ff(tok_fwd_ff), .ifm_clr_ff(ifm_clr_ff),
        .mode_ff(mode_ff), .dev_addr_ff(dev_addr_ff), .func_ff(func_ff), .otg_ff(otg_ff),
        .serial_ctl_ff(serial_ctl_ff), .port_ff(port_ff));
    uic_xcvr_model u_uic_xcvr_model (.core_clk(core_clk), .otg(otg_ff), .otg_flags(otg_flags), .rx_line(rx_line));
    // 4 ns clock and a cycle ceiling against hangs
    initial forever #2 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            give_verdict();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask : chk
    // one 32-bit access to peripheral p; ack expected only for the bank's own number
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [7:0] p = 8'h01);
        @(posedge core_clk);
        req <= {p, w, ~w, a, d};
        @(posedge core_clk);
        req <= '0;
        #1;
        chk("ack", p == 8'h01, ack_ff);
        rd = rdata_ff;
        clr = ifm_clr_ff;
    endtask : acc
    task automatic t_reset();
        acc(0, 8'h04, 0); chk("mode rst", 32'h0, rd);
        acc(0, 8'h08, 0); chk("addr rst", 32'h0, rd);
        acc(0, 8'h0C, 0); chk("func rst", 32'h07, rd);
        acc(0, 8'h10, 0); chk("otg rst", 32'h0, rd);
        chk("serial rst", 4'h2, serial_ctl_ff);
        $display("test reset done");
    endtask : t_reset
    // walk one bit at a time through mode and otg registers
    task automatic t_bits();
        for (int i = 0; i < 8; i++) begin
            acc(1, 8'h04, 32'hFFFFFF00 | (1 << i));
            acc(0, 8'h04, 0); chk("mode", (1 << i) & 32'hF7, rd);
            acc(1, 8'h10, 32'hFFFFFF00 | (1 << i));
            acc(0, 8'h10, 0); chk("otg", (1 << i) & 32'hDF, rd);
        end
        chk("mode out", 7'h40, mode_ff);
        chk("otg out", 7'h40, otg_ff);
        acc(1, 8'h10, 32'h10);
        acc(0, 8'h14, 0); chk("vbus flag", 32'h1, rd);
        // the model answers the d-plus pull-down on its line status, read back beside the serial controls
        acc(1, 8'h10, 32'h02);
        acc(0, 8'h18, 0); chk("line", 32'h12, rd);
        $display("test bits done");
    endtask : t_bits
    task automatic t_func();
        acc(1, 8'h0C, 0); chk("func off", 5'h00, func_ff);
        acc(1, 8'h0C, 32'hFFFFFFFF);
        acc(0, 8'h0C, 0); chk("func all", 32'h1F, rd);
        $display("test func done");
    endtask : t_func
    task automatic tok(input logic [6:0] a, input logic e);
        @(posedge core_clk);
        tok_valid <= 1;
        tok_addr <= a;
        @(posedge core_clk);
        tok_valid <= 0;
        #1;
        chk("fwd", e, tok_fwd_ff);
    endtask : tok
    task automatic t_addr_soft();
        acc(1, 8'h08, 32'hFFFFFF85);
        acc(0, 8'h08, 0); chk("addr", 32'h05, rd);
        chk("addr out", 7'h05, dev_addr_ff);
        // port 0 follows the token flag: flag one cycle after the strobe, port one cycle later
        acc(1, 8'h24, 32'h00000040);
        tok(7'h05, 1);
        @(posedge core_clk);
        #1;
        chk("port", 4'h1, port_ff);
        tok(7'h06, 0);
        acc(1, 8'h04, 32'h03, 8'h02); chk("foreign", 7'h40, mode_ff);
        acc(1, 8'h00, 32'h0); chk("clr", 32'h1, clr);
        acc(0, 8'h04, 0); chk("mode clr", 32'h0, rd);
        chk("addr clr", 7'h00, dev_addr_ff);
        chk("func kept", 5'h1F, func_ff);
        $display("test address and soft reset done");
    endtask : t_addr_soft
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (10) @(posedge core_clk);
        reset <= 0;
        t_reset();
        t_bits();
        t_func();
        t_addr_soft();
        give_verdict();
    end
endmodule : testbench
